// >>> include/barl_defs.vh
// Codes and register map for the address status / response retry block.
// Assumes inclusion by bare name from the design file.
`ifndef BARL_DEFS_VH
`define BARL_DEFS_VH
// Status codes (2 bits)
`define BARL_AST_NULL 2'h0
`define BARL_AST_RETRY 2'h1
`define BARL_AST_PARERR 2'h2
`define BARL_AST_POSACK 2'h3
`define BARL_AST_NO_ACK_CODE 2'h0
// Response codes (3 bits)
`define BARL_RSP_NULL 3'h0
`define BARL_RSP_RETRY 3'h1
`define BARL_RSP_SHARED 3'h2
`define BARL_RSP_MODIFIED 3'h3
`define BARL_RSP_RERUN 3'h4
// Register byte offsets
`define BARL_REG_CTRL 8'h00
`define BARL_REG_STAT 8'h04
`define BARL_REG_LAT 8'h08
// Control field positions
`define BARL_CTRL_SNP_EN 0
`define BARL_CTRL_PAR_EN 1
`define BARL_CTRL_POSACK_EN 2
`define BARL_CTRL_MCHK_EN 3
`define BARL_CTRL_RESET 32'h0000_0000
// Status field positions
`define BARL_STAT_PARERR0 0
`define BARL_STAT_POSACKERR 1
`define BARL_STAT_STCX_FAIL 2
`define BARL_STAT_TLBI_BUSY 3
// Latency
`define BARL_LAT_RESET 4'h8
`define BARL_LAT_MIN 4'h2
`endif

// >>> rtl/barl_retry_logic.v
// Address status and address response logic for master and snooper roles.
// Assumes bus codes sampled synchronously to i_ref_clk; registers on classic Wishbone.
// Assumes one operation per phase strobe and that the far side combines codes.
// Assumes the invalidate done pulse comes from the translation logic.
`include "barl_defs.vh"
`default_nettype none

module barl_retry_logic #(
  parameter SNP_BUFS = 4
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Status phase inputs
  input wire i_address_status_phase_phase,
  input wire i_my_op,
  input wire i_prev_adj_match,
  input wire i_addr_par_err,
  input wire [SNP_BUFS-1:0] i_snp_buf_busy,
  input wire i_snp_buf_hit,
  input wire i_non_mc_op,
  input wire i_tlbi_op,
  input wire i_sync_class_op,
  input wire i_snp_sm_free,
  input wire i_tlbi_done,
  input wire i_aresp_disabled_op,
  input wire i_posack_enabled_op,
  input wire [1:0] i_addr_status_sample,
  // Response phase inputs
  input wire i_aresp_phase,
  input wire i_cd_enabled_op,
  input wire i_cd_in,
  input wire i_cistcx,
  input wire i_reservation,
  input wire i_lr_or_dc,
  input wire i_wr_nonflush,
  input wire i_snp_hit,
  input wire i_push_needed,
  input wire i_l2_ue,
  input wire [2:0] i_addr_response_sample,
  // Outputs
  output reg [1:0] o_addr_status_drive,
  output reg [2:0] o_addr_response_drive,
  output reg o_mst_complete,
  output reg o_mst_restart,
  output reg o_mst_to_lsu,
  output reg o_mst_hold_cd,
  output reg o_mst_resp_phase,
  output reg o_snp_abort,
  output reg o_snp_complete,
  output reg o_snp_resp_phase,
  output reg o_queue_release,
  output reg o_mchk,
  output reg o_checkstop,
  output reg o_stcx_fail
);

  // Software-visible control and flags
  reg [3:0] ctrl_q;
  reg [3:0] lat_q;
  reg par_err_q;
  reg posack_err_q;
  reg stcx_fail_q;
  // Invalidate tracker, one-hot; only one invalidate is worked on
  localparam [1:0] TLBI_IDLE = 2'h1;
  localparam [1:0] TLBI_BUSY = 2'h2;
  reg [1:0] tlbi_st_q;
  reg [1:0] tlbi_st_d;
  wire tlbi_busy = tlbi_st_q[1];
  // Pending abort, one clock after retry sample
  reg abort_pend_q;

  wire snoop_enable = ctrl_q[`BARL_CTRL_SNP_EN];
  wire parity_check_enable = ctrl_q[`BARL_CTRL_PAR_EN];
  wire positive_ack_enable = ctrl_q[`BARL_CTRL_POSACK_EN];
  wire machine_check_enable = ctrl_q[`BARL_CTRL_MCHK_EN];

  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // Writes land at the edge where the master sees ack high
  wire wb_wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];

  // Busy chain per snoop buffer; retry only when every buffer is taken
  wire [SNP_BUFS:0] busy_chain;
  assign busy_chain[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < SNP_BUFS; gi = gi + 1) begin : g_buf
      assign busy_chain[gi+1] = busy_chain[gi] & i_snp_buf_busy[gi];
    end
  endgenerate
  wire all_bufs_busy = busy_chain[SNP_BUFS];

  // Acceptance of acknowledge code
  wire ack_is_ok = i_posack_enabled_op ?
      (positive_ack_enable ? (i_addr_status_sample == `BARL_AST_POSACK) :
       ((i_addr_status_sample == `BARL_AST_POSACK) |
        (i_addr_status_sample == `BARL_AST_NO_ACK_CODE))) :
      ((i_addr_status_sample == `BARL_AST_POSACK) |
       (i_addr_status_sample == `BARL_AST_NO_ACK_CODE));

  wire st_par = i_addr_status_sample == `BARL_AST_PARERR;
  wire st_retry = i_addr_status_sample == `BARL_AST_RETRY;
  wire rsp_retry = i_addr_response_sample == `BARL_RSP_RETRY;
  wire cd_is_not_ok = i_cd_enabled_op & ~i_cd_in;
  wire lat_low = lat_q < `BARL_LAT_MIN;

  // Status decision for master and snooper; slaves-only retry rule left to the addressed slave
  reg [1:0] ast_d;
  always @* begin
    ast_d = `BARL_AST_NULL;
    if (i_my_op) begin
      if (i_prev_adj_match) begin
        ast_d = `BARL_AST_RETRY;
      end
    end else if (i_addr_par_err & parity_check_enable) begin
      ast_d = `BARL_AST_PARERR;
    end else if (snoop_enable) begin
      if (all_bufs_busy | (i_non_mc_op & ~i_snp_buf_hit)) begin
        ast_d = `BARL_AST_RETRY;
      end else if (i_sync_class_op & ~i_snp_sm_free) begin
        ast_d = `BARL_AST_RETRY;
      end else if (i_tlbi_op & tlbi_busy) begin
        ast_d = `BARL_AST_RETRY;
      end
    end
  end

  // Response drive decision
  reg [2:0] rsp_d;
  always @* begin
    rsp_d = `BARL_RSP_NULL;
    if (i_my_op) begin
      if (cd_is_not_ok | (i_cistcx & ~i_reservation)) begin
        rsp_d = `BARL_RSP_RETRY;
      end
    end else if (snoop_enable) begin
      if (i_push_needed | (i_snp_hit & ~i_snp_sm_free)) begin
        rsp_d = `BARL_RSP_RETRY;
      end else if (i_l2_ue | lat_low) begin
        rsp_d = `BARL_RSP_RETRY;
      end
    end
  end

  // Register bus: single-cycle ack, unmapped reads zero
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      ctrl_q <= 4'h0;
      lat_q <= `BARL_LAT_RESET;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0000_0000;
      if (wb_wr && i_wb_adr == `BARL_REG_CTRL) begin
        ctrl_q <= i_wb_dat[3:0];
      end
      if (wb_wr && i_wb_adr == `BARL_REG_LAT) begin
        lat_q <= i_wb_dat[3:0];
      end
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          `BARL_REG_CTRL: o_wb_dat <= {28'h000_0000, ctrl_q};
          `BARL_REG_STAT: o_wb_dat <= {28'h000_0000, tlbi_busy, stcx_fail_q,
                                       posack_err_q, par_err_q};
          `BARL_REG_LAT: o_wb_dat <= {28'h000_0000, lat_q};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Write-one-to-clear of status; a hardware set in the same cycle wins
  wire stat_clr = wb_wr && i_wb_adr == `BARL_REG_STAT;
  wire set_par = i_address_status_phase_phase & i_my_op & st_par;
  wire set_pak = i_address_status_phase_phase & i_my_op & ~st_par & ~st_retry & ~ack_is_ok;
  wire set_stcx = i_aresp_phase & i_my_op & rsp_retry & i_cistcx & ~i_reservation;
  wire tlbi_take = i_address_status_phase_phase & ~i_my_op & snoop_enable & i_tlbi_op & ~tlbi_busy;

  // Phase strobes split by role
  wire mst_stat = i_address_status_phase_phase & i_my_op;
  wire snp_stat = i_address_status_phase_phase & ~i_my_op;
  wire mst_resp = i_aresp_phase & i_my_op;
  wire snp_resp = i_aresp_phase & ~i_my_op;

  // Invalidate tracker next state; a take only happens from idle
  always @* begin
    tlbi_st_d = tlbi_st_q;
    case (tlbi_st_q)
      TLBI_IDLE: begin
        if (tlbi_take) begin
          tlbi_st_d = TLBI_BUSY;
        end
      end
      TLBI_BUSY: begin
        if (i_tlbi_done) begin
          tlbi_st_d = TLBI_IDLE;
        end
      end
      default: begin
        tlbi_st_d = TLBI_IDLE;
      end
    endcase
  end

  // Invalidate tracker state; an illegal code falls back to idle
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tlbi_st_q <= TLBI_IDLE;
    end else begin
      tlbi_st_q <= tlbi_st_d;
    end
  end

  // Codes are shown for exactly one cycle after each phase strobe
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr_status_drive <= `BARL_AST_NULL;
      o_addr_response_drive <= `BARL_RSP_NULL;
    end else begin
      o_addr_status_drive <= i_address_status_phase_phase ? ast_d : `BARL_AST_NULL;
      o_addr_response_drive <= i_aresp_phase ? rsp_d : `BARL_RSP_NULL;
    end
  end

  // Abort lands one clock after the retry sample; the slot is then free
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      abort_pend_q <= 1'b0;
      o_queue_release <= 1'b0;
    end else begin
      abort_pend_q <= i_address_status_phase_phase & st_retry;
      o_queue_release <= abort_pend_q;
    end
  end

  // Sticky flags; a hardware set outranks a clear in the same cycle
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      par_err_q <= 1'b0;
      posack_err_q <= 1'b0;
      stcx_fail_q <= 1'b0;
    end else begin
      par_err_q <= set_par | (par_err_q & ~(stat_clr & i_wb_dat[`BARL_STAT_PARERR0]));
      posack_err_q <= set_pak |
          (posack_err_q & ~(stat_clr & i_wb_dat[`BARL_STAT_POSACKERR]));
      stcx_fail_q <= set_stcx |
          (stcx_fail_q & ~(stat_clr & i_wb_dat[`BARL_STAT_STCX_FAIL]));
    end
  end

  // Machine check causes; the enable picks trap or checkstop
  wire mchk_cause = (mst_stat & st_par & positive_ack_enable) |
      (mst_stat & ~st_par & ~st_retry & ~ack_is_ok) |
      (snp_stat & st_par);
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mchk <= 1'b0;
      o_checkstop <= 1'b0;
    end else begin
      o_mchk <= mchk_cause & machine_check_enable;
      o_checkstop <= mchk_cause & ~machine_check_enable;
    end
  end

  // Master outcomes; response phase pulses are ORed with status pulses of the same cycle
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mst_complete <= 1'b0;
      o_mst_restart <= 1'b0;
      o_mst_to_lsu <= 1'b0;
      o_mst_hold_cd <= 1'b0;
      o_mst_resp_phase <= 1'b0;
      o_stcx_fail <= 1'b0;
    end else begin
      o_mst_complete <= 1'b0;
      o_mst_restart <= 1'b0;
      o_mst_to_lsu <= 1'b0;
      o_mst_hold_cd <= 1'b0;
      o_mst_resp_phase <= 1'b0;
      o_stcx_fail <= 1'b0;
      // Status phase, highest priority code first
      if (mst_stat) begin
        if (st_par) begin
          o_mst_complete <= 1'b1;
        end else if (st_retry) begin
          o_mst_restart <= 1'b1;
        end else if (!ack_is_ok) begin
          o_mst_complete <= 1'b1;
        end else if (i_aresp_disabled_op) begin
          o_mst_complete <= 1'b1;
        end else begin
          o_mst_resp_phase <= 1'b1;
        end
      end
      // Conditional store is judged before plain writes, being atomic
      if (mst_resp) begin
        if (rsp_retry && i_cistcx && !i_reservation) begin
          o_stcx_fail <= 1'b1;
          o_mst_complete <= 1'b1;
        end else if (!rsp_retry || i_wr_nonflush) begin
          o_mst_complete <= 1'b1;
        end else if (cd_is_not_ok && i_lr_or_dc) begin
          o_mst_to_lsu <= 1'b1;
        end else begin
          // Collision case waits in the bus interface unit first
          o_mst_hold_cd <= cd_is_not_ok;
          o_mst_restart <= 1'b1;
        end
      end
    end
  end

  // Snooper outcomes; a response retry leaves the cache state untouched
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_snp_abort <= 1'b0;
      o_snp_complete <= 1'b0;
      o_snp_resp_phase <= 1'b0;
    end else begin
      o_snp_abort <= 1'b0;
      o_snp_complete <= 1'b0;
      o_snp_resp_phase <= 1'b0;
      if (snp_stat) begin
        if (st_par | st_retry | ~ack_is_ok) begin
          o_snp_abort <= 1'b1;
        end else if (i_aresp_disabled_op) begin
          o_snp_complete <= 1'b1;
        end else begin
          o_snp_resp_phase <= 1'b1;
        end
      end
      if (snp_resp) begin
        if (rsp_retry) begin
          o_snp_abort <= 1'b1;
        end else begin
          o_snp_complete <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> sim/barl_retry_logic_asserts.sv
// Checker for the retry block, watching its top-level ports only.
// Assumes one-cycle registered answers after each phase strobe.
`include "barl_defs.vh"
`default_nettype none
module barl_chk (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_address_status_phase_phase,
  input wire logic i_my_op,
  input wire logic i_prev_adj_match,
  input wire logic i_posack_enabled_op,
  input wire logic i_aresp_disabled_op,
  input wire logic [1:0] i_addr_status_sample,
  input wire logic i_aresp_phase,
  input wire logic i_cd_enabled_op,
  input wire logic i_cd_in,
  input wire logic i_cistcx,
  input wire logic i_reservation,
  input wire logic [2:0] i_addr_response_sample,
  input wire logic [1:0] o_addr_status_drive,
  input wire logic [2:0] o_addr_response_drive,
  input wire logic o_mst_complete,
  input wire logic o_mst_restart,
  input wire logic o_mst_resp_phase,
  input wire logic o_snp_abort,
  input wire logic o_mchk,
  input wire logic o_checkstop,
  input wire logic o_queue_release,
  input wire logic o_stcx_fail
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Master status strobe without a response strobe, so no response pulse is ORed in; the snoop strobe is not gated
  wire mst_st = i_address_status_phase_phase && i_my_op && !i_aresp_phase;
  wire snp_st = i_address_status_phase_phase && !i_my_op;
  wire ack_ok = !i_posack_enabled_op && i_addr_status_sample == `BARL_AST_POSACK;
  sequence sq_retry;
    i_address_status_phase_phase && i_addr_status_sample == `BARL_AST_RETRY;
  endsequence
  AST_ABORT_LATE: assert property (sq_retry |-> ##2 o_queue_release)
    else $error("queue release missing after retry");
  AST_MST_STAT: assert property (i_address_status_phase_phase && i_my_op |=>
    o_addr_status_drive == ($past(i_prev_adj_match) ? `BARL_AST_RETRY : `BARL_AST_NULL))
    else $error("master status code wrong");
  AST_STAT_IDLE: assert property (!i_address_status_phase_phase |=> o_addr_status_drive == `BARL_AST_NULL)
    else $error("status code outside phase");
  AST_RESTART: assert property (mst_st && i_addr_status_sample == `BARL_AST_RETRY |=>
    o_mst_restart && !o_mst_resp_phase) else $error("retry did not restart");
  AST_GOOD_ACK: assert property (mst_st && ack_ok |=>
    ($past(i_aresp_disabled_op) ? o_mst_complete : o_mst_resp_phase))
    else $error("good acknowledge mishandled");
  AST_SNP_PAR: assert property (snp_st && i_addr_status_sample == `BARL_AST_PARERR |=>
    o_snp_abort && (o_mchk || o_checkstop)) else $error("snoop parity not aborted");
  AST_RSP_RETRY: assert property (i_aresp_phase && i_my_op && (i_cd_enabled_op && !i_cd_in
    || i_cistcx && !i_reservation) |=> o_addr_response_drive == `BARL_RSP_RETRY)
    else $error("master response retry missing");
  AST_STCX: assert property (i_aresp_phase && i_my_op && i_cistcx && !i_reservation &&
    i_addr_response_sample == `BARL_RSP_RETRY |=> o_stcx_fail && o_mst_complete)
    else $error("conditional store not failed");
endmodule
bind barl_retry_logic barl_chk u_chk (.*);
`default_nettype wire

// >>> sim/barl_bus_model.sv
// Far side: addressed slave, other snoopers and the code collection logic.
// Assumes bench requests change just after a rising edge.
`include "barl_defs.vh"
`default_nettype none
module barl_bus_model (
  input wire logic i_ref_clk,
  input wire logic i_stat_req,
  input wire logic i_resp_req,
  input wire logic i_resp_dis,
  input wire logic [1:0] i_slave_code,
  input wire logic [1:0] i_snoop_code,
  input wire logic [2:0] i_resp_code,
  output var logic o_address_status_phase_phase,
  output var logic o_aresp_phase,
  output var logic [1:0] o_status,
  output var logic [2:0] o_response
);
  // Other snoopers may not retry a response-disabled op
  wire [1:0] snp = (i_resp_dis && i_snoop_code == `BARL_AST_RETRY) ? 2'h0 : i_snoop_code;
  // Combine codes, parity error first
  always @(posedge i_ref_clk) begin
    o_address_status_phase_phase <= i_stat_req;
    o_aresp_phase <= i_resp_req;
    o_response <= i_resp_code;
    if (i_slave_code == `BARL_AST_PARERR || snp == `BARL_AST_PARERR)
      o_status <= `BARL_AST_PARERR;
    else if (i_slave_code == `BARL_AST_RETRY || snp == `BARL_AST_RETRY)
      o_status <= `BARL_AST_RETRY;
    else
      o_status <= i_slave_code | snp;
  end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Random master and snooper phases checked against an integer model.
// Assumes the far-side model feeds strobes and combined codes.
`include "barl_defs.vh"
`default_nettype none
`define CHK(A, B) begin comparisons++; if ((A) !== (B)) begin errors++; \
  $display("wrong value at %0t: got %0h want %0h", $time, A, B); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_sys_rst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
  logic [7:0] i_wb_adr = 0;
  logic [3:0] i_wb_sel = 4'hf, i_snp_buf_busy = 0;
  logic [31:0] i_wb_dat = 0, q;
  logic i_my_op = 0, i_prev_adj_match = 0, i_addr_par_err = 0, i_snp_buf_hit = 0;
  logic i_non_mc_op = 0, i_tlbi_op = 0, i_sync_class_op = 0, i_snp_sm_free = 0;
  logic i_tlbi_done = 0, i_aresp_disabled_op = 0, i_posack_enabled_op = 0, i_cistcx = 0;
  logic i_cd_enabled_op = 0, i_cd_in = 0, i_reservation = 0, i_lr_or_dc = 0, i_snp_hit = 0;
  logic i_wr_nonflush = 0, i_push_needed = 0, i_l2_ue = 0, sreq = 0, rreq = 0;
  logic [1:0] slv = 0, oth = 0;
  logic [2:0] rsp = 0;
  wire [31:0] o_wb_dat;
  wire [1:0] i_addr_status_sample, o_addr_status_drive;
  wire [2:0] i_addr_response_sample, o_addr_response_drive;
  wire i_address_status_phase_phase, i_aresp_phase, o_wb_ack, o_mst_complete, o_mst_restart, o_mst_to_lsu;
  wire o_mst_hold_cd, o_mst_resp_phase, o_snp_abort, o_snp_complete, o_snp_resp_phase;
  wire o_queue_release, o_mchk, o_checkstop, o_stcx_fail;
  wire m = i_my_op;
  int errors = 0, comparisons = 0, e, s, rs, ok, mc, cl, ctrl, lat, stat = 0, tbb = 0;
  int unsigned seed = 51, r;
  barl_retry_logic dut (.*);
  barl_bus_model far (.i_ref_clk(i_ref_clk), .i_stat_req(sreq), .i_resp_req(rreq),
    .i_resp_dis(i_aresp_disabled_op), .i_slave_code(slv), .i_snoop_code(oth),
    .i_resp_code(rsp), .o_address_status_phase_phase(i_address_status_phase_phase), .o_aresp_phase(i_aresp_phase),
    .o_status(i_addr_status_sample), .o_response(i_addr_response_sample));
  // Free-running 125 MHz clock
  always #4 i_ref_clk = ~i_ref_clk;
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Classic cycle; waits on ack, watchdog bounds the wait
  task automatic wb(input bit we, input [7:0] a, input [31:0] d, output [31:0] rd);
    @(posedge i_ref_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, we, a, d};
    @(posedge i_ref_clk);
    while (o_wb_ack !== 1'b1) @(posedge i_ref_clk);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
  endtask
  task print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  // Register checks, then random phases
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 0;
    wb(0, 8'h08, 0, q);
    `CHK(q, 32'h8)
    wb(0, 8'h0c, 0, q);
    `CHK(q, 32'h0)
    $display("test registers done");
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      ctrl = r[3:0];
      lat = r[7:4];
      wb(1, 8'h00, ctrl, q);
      wb(1, 8'h08, lat, q);
      r = rnd();
      {i_my_op, i_prev_adj_match, i_addr_par_err, i_snp_buf_hit, i_non_mc_op,
        i_sync_class_op, i_snp_sm_free, i_aresp_disabled_op, i_posack_enabled_op,
        i_cd_enabled_op, i_cistcx, i_reservation, i_lr_or_dc, i_snp_hit, i_push_needed,
        i_l2_ue, slv, oth} <= r[19:0];
      i_cd_in <= r[20] | ~r[19];
      i_wr_nonflush <= r[21] & ~r[7] & ~r[9];
      i_snp_buf_busy <= r[22] ? 4'hf : r[26:23];
      rsp <= 3'(r[31:29] % 5);
      i_tlbi_op <= r[27];
      i_tlbi_done <= r[28];
      sreq <= 1;
      @(posedge i_ref_clk) sreq <= 0;
      @(posedge i_ref_clk) rreq <= 1;
      @(negedge i_ref_clk);
      s = i_addr_status_sample;
      ok = (!i_posack_enabled_op || !ctrl[2]) ? (s == 3 || s == 0) : s == 3;
      if (m) e = i_prev_adj_match;
      else if (i_addr_par_err && ctrl[1]) e = 2;
      else e = ctrl[0] && (&i_snp_buf_busy || i_non_mc_op && !i_snp_buf_hit
        || i_sync_class_op && !i_snp_sm_free || i_tlbi_op && tbb && !i_tlbi_done);
      `CHK(o_addr_status_drive, 2'(e))
      tbb = (tbb || !m && ctrl[0] && i_tlbi_op) && !i_tlbi_done;
      mc = m ? (s == 2 && ctrl[2] || s != 1 && s != 2 && !ok) : s == 2;
      `CHK({o_mchk, o_checkstop}, {mc && ctrl[3], mc && !ctrl[3]})
      e = {m && s == 1, m && ok && !i_aresp_disabled_op, !m && !ok};
      `CHK({o_mst_restart, o_mst_resp_phase, o_snp_abort}, 3'(e))
      `CHK(o_snp_resp_phase, !m && ok && !i_aresp_disabled_op)
      e = {m && s != 1 && (!ok || i_aresp_disabled_op), !m && ok && i_aresp_disabled_op};
      `CHK({o_mst_complete, o_snp_complete}, 2'(e))
      stat |= (m && s == 2) | ((m && s != 1 && s != 2 && !ok) << 1);
      @(posedge i_ref_clk) rreq <= 0;
      @(negedge i_ref_clk);
      `CHK(o_queue_release, s == 1)
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      rs = i_addr_response_sample;
      if (m) e = i_cd_enabled_op && !i_cd_in || i_cistcx && !i_reservation;
      else e = ctrl[0] && (i_push_needed || i_snp_hit && !i_snp_sm_free || i_l2_ue || lat < 2);
      `CHK(o_addr_response_drive, 3'(e))
      e = m && i_cistcx && !i_reservation && rs == 1;
      `CHK(o_stcx_fail, 1'(e))
      stat |= e << 2;
      cl = m && rs == 1 && !(i_cistcx && !i_reservation) && i_cd_enabled_op && !i_cd_in;
      e = {cl && i_lr_or_dc, cl && !i_lr_or_dc && !i_wr_nonflush, !m && rs == 1};
      `CHK({o_mst_to_lsu, o_mst_hold_cd, o_snp_abort}, 3'(e))
      e = {m && rs == 1 && !i_wr_nonflush && !(i_cistcx && !i_reservation)
        && !(cl && i_lr_or_dc), m && (rs != 1 || i_wr_nonflush || i_cistcx && !i_reservation),
        !m && rs != 1};
      `CHK({o_mst_restart, o_mst_complete, o_snp_complete}, 3'(e))
      wb(0, 8'h04, 0, q);
      `CHK(q, 32'(stat | (tbb << 3)))
      wb(1, 8'h04, 7, q);
      stat = 0;
    end
    $display("test phases done");
    print_verdict();
  end
endmodule
`default_nettype wire
